/* File: rtl/dmm_consts.svh */
// constants for the display mapping metadata link: field layout, lengths, defaults
// assumes both ends include this file and import dmm_pkg for the types
// Notes on behaviour
// [RQ1] picture peak code 12 bits, out-of-range flagged
// [RQ2] picture mean code passed through unchanged
// [RQ3] target display peak code 12 bits, 0..4095
// [RQ4] repeated target peak within message is error; the parser remembers only the first 16 distinct targets of a message
// [RQ5] trims 0..4095; absent trim becomes 2048
// [RQ6] encoder quantizes trims from normalized value times 4096
// [RQ7] encoder rounds luminance times 4095, clips 0..4095
// [RQ8] reserved signed weight must be all ones
// [RQ9] active-area edge offsets lie in 0..8191
// [RQ10] corners: left/top, and size minus one minus offset
// [RQ11] padding bits after used payload must be zero
// [RQ12] payload bits are eight times byte length
// [RQ13] reserved levels: whole payload skipped silently
// [RQ14] each decoded block gets valid strobe and error flags
`ifndef DMM_CONSTS_SVH
`define DMM_CONSTS_SVH
`define DMM_PAY_W 85
`define DMM_CODE_MAX 12'hFFF
`define DMM_EDGE_MAX 13'h1FFF
`define DMM_TRIM_DEFAULT 12'h800
`define DMM_TRIM_HALF 16'h0800
`define DMM_WEIGHT_RSVD 13'h1FFF
`define DMM_LEVEL_RANGE 8'h01
`define DMM_LEVEL_TRIM 8'h02
`define DMM_LEVEL_AREA 8'h05
`define DMM_L1_USE 13'h0024
`define DMM_L2_USE 13'h0055
`define DMM_L5_USE 13'h0034
`define DMM_L1_LEN 10'h005
`define DMM_L2_LEN 10'h00B
`define DMM_L5_LEN 10'h007
`define DMM_SEEN_N 16
`define DMM_LUM_SCALE 30'h00000FFF
`define DMM_FRAC_BITS 14
`define DMM_ERR_RANGE 0
`define DMM_ERR_DUP 1
`define DMM_ERR_WEIGHT 2
`define DMM_ERR_PAD 3
`define DMM_ERR_LEN 4
`endif

/* File: rtl/dmm_pkg.sv */
// types shared by the metadata source end and the parser end
// assumes dmm_consts.svh is included before use of the widths
`include "dmm_consts.svh"
package dmm_pkg;
    typedef enum logic [1:0] {DMM_P_IDLE, DMM_P_BITS, DMM_P_DONE} dmm_pst_t;
    typedef enum logic [1:0] {DMM_S_IDLE, DMM_S_HDR, DMM_S_BITS} dmm_sst_t;
    typedef struct packed {
        dmm_pst_t st;
        logic [12:0] bitcnt;
        logic [12:0] lenbits;
        logic [9:0] len;
        logic [7:0] level;
        logic [`DMM_PAY_W-1:0] pay;
        logic pad_err;
        logic [`DMM_SEEN_N-1:0][11:0] seen;
        logic [4:0] nseen;
        logic blk_valid;
        logic [7:0] blk_level;
        logic [4:0] err;
        logic [11:0] min_code;
        logic [11:0] peak_code;
        logic [11:0] mean_code;
        logic [11:0] target_code;
        logic [4:0][11:0] trim;
        logic [15:0] ul_x;
        logic [15:0] ul_y;
        logic [15:0] lr_x;
        logic [15:0] lr_y;
    } dmm_pstate_t;
    typedef struct packed {
        dmm_sst_t st;
        logic [12:0] bitcnt;
        logic [12:0] lenbits;
        logic [`DMM_PAY_W-1:0] pay;
        logic first;
        logic [7:0] level;
        logic [9:0] len;
    } dmm_sstate_t;
endpackage

/* File: rtl/dmm_link_if.sv */
// link between the metadata source end and the parser end
// assumes one clock shared by both ends; header then payload bits, msb first
`timescale 1ns/1ps
interface dmm_link_if;
    logic hdr_valid;
    logic hdr_first;
    logic [7:0] hdr_level;
    logic [9:0] hdr_len;
    logic hdr_ready;
    logic bit_valid;
    logic bit_data;
    logic bit_ready;
    modport source (output hdr_valid, hdr_first, hdr_level, hdr_len, bit_valid, bit_data,
                    input hdr_ready, bit_ready);
    modport parser (input hdr_valid, hdr_first, hdr_level, hdr_len, bit_valid, bit_data,
                    output hdr_ready, bit_ready);
endinterface

/* File: rtl/dmm_source.sv */
// metadata source end: quantizes block fields and sends header plus payload bits
// assumes the parser end drains the link through the ready signals
`timescale 1ns/1ps
`include "dmm_consts.svh"
module dmm_source
    import dmm_pkg::*;
(
    input wire logic clk_i, // 100 MHz clock
    input wire logic resetn_i, // async reset, active low
    dmm_link_if.source link, // link to the parser
    input wire logic req_valid_i, // block request
    output logic req_ready_o, // block request taken
    input wire logic req_first_i, // block is first of message
    input wire logic [7:0] req_level_i, // block level
    input wire logic [9:0] req_len_i, // payload length in bytes
    input wire logic [2:0][15:0] lum_i, // min, peak, mean, unsigned Q2.14
    input wire logic [11:0] target_code_i, // target display peak code
    input wire logic [4:0][15:0] trim_i, // slope, offset, power, chroma, sat, Q2.14
    input wire logic [3:0][12:0] edge_i // left, right, top, bottom offsets
);
    dmm_sstate_t s_reg;
    dmm_sstate_t s_next;

    function automatic logic [11:0] q_lum(input logic [15:0] x);
        logic [29:0] p;
        p = 30'(x) * `DMM_LUM_SCALE + 30'h00002000;
        p = p >> `DMM_FRAC_BITS;
        q_lum = (p > 30'(`DMM_CODE_MAX)) ? `DMM_CODE_MAX : p[11:0]; // RQ7
    endfunction

    function automatic logic [11:0] q_trim(input logic [15:0] x, input logic plus);
        logic signed [17:0] r;
        r = 18'(({2'h0, x} + 18'h00002) >> 2);
        r = plus ? r + 18'(`DMM_TRIM_HALF) : r - 18'(`DMM_TRIM_HALF);
        if (r < 0)
        begin
            q_trim = 12'h000; // RQ6
        end
        else if (r > 18'(`DMM_CODE_MAX))
        begin
            q_trim = `DMM_CODE_MAX;
        end
        else
        begin
            q_trim = r[11:0];
        end
    endfunction

    always_comb
    begin
        s_next = s_reg;
        req_ready_o = (s_reg.st == DMM_S_IDLE);
        unique case (s_reg.st)
            DMM_S_IDLE:
            begin
                if (req_valid_i)
                begin
                    s_next.first = req_first_i;
                    s_next.level = req_level_i;
                    s_next.len = req_len_i;
                    s_next.lenbits = {req_len_i, 3'h0};
                    s_next.bitcnt = 13'h0000;
                    s_next.pay = '0;
                    if (req_level_i == `DMM_LEVEL_RANGE)
                    begin
                        s_next.pay[84:49] = {q_lum(lum_i[0]), q_lum(lum_i[1]), q_lum(lum_i[2])}; // RQ7
                    end
                    else if (req_level_i == `DMM_LEVEL_TRIM)
                    begin
                        s_next.pay = {target_code_i, q_trim(trim_i[0], 1'b0), q_trim(trim_i[1], 1'b1),
                                      q_trim(trim_i[2], 1'b0), q_trim(trim_i[3], 1'b1),
                                      q_trim(trim_i[4], 1'b1), `DMM_WEIGHT_RSVD}; // RQ6 RQ8
                    end
                    else if (req_level_i == `DMM_LEVEL_AREA)
                    begin
                        s_next.pay[84:33] = {edge_i[0], edge_i[1], edge_i[2], edge_i[3]};
                    end
                    s_next.st = DMM_S_HDR;
                end
            end
            DMM_S_HDR:
            begin
                if (link.hdr_ready)
                begin
                    s_next.st = (s_reg.lenbits == 13'h0000) ? DMM_S_IDLE : DMM_S_BITS;
                end
            end
            DMM_S_BITS:
            begin
                if (link.bit_ready)
                begin
                    s_next.pay = {s_reg.pay[`DMM_PAY_W-2:0], 1'b0}; // RQ11
                    s_next.bitcnt = s_reg.bitcnt + 13'h0001;
                    if (s_reg.bitcnt + 13'h0001 == s_reg.lenbits) // RQ12
                    begin
                        s_next.st = DMM_S_IDLE;
                    end
                end
            end
        endcase
    end

    assign link.hdr_valid = (s_reg.st == DMM_S_HDR);
    assign link.hdr_first = s_reg.first;
    assign link.hdr_level = s_reg.level;
    assign link.hdr_len = s_reg.len;
    assign link.bit_valid = (s_reg.st == DMM_S_BITS);
    assign link.bit_data = s_reg.pay[`DMM_PAY_W-1];

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            s_reg <= '{st: DMM_S_IDLE, default: '0};
        end
        else
        begin
            s_reg <= s_next;
        end
    end
endmodule

/* File: rtl/dmm_parser.sv */
// parser end: checks and decodes level 1, 2 and 5 payloads into registered fields
// assumes the source end keeps header and bit valid until the matching ready
`timescale 1ns/1ps
`include "dmm_consts.svh"
module dmm_parser
    import dmm_pkg::*;
(
    input wire logic clk_i, // 100 MHz clock
    input wire logic resetn_i, // async reset, active low
    dmm_link_if.parser link, // link from the source
    input wire logic [15:0] pic_width_i, // picture width in pixels
    input wire logic [15:0] pic_height_i, // picture height in pixels
    output logic blk_valid_o, // one-cycle pulse per decoded block
    output logic [7:0] blk_level_o, // level of decoded block
    output logic blk_err_o, // block does not conform
    output logic [4:0] blk_err_flags_o, // range, dup, weight, pad, length
    output logic [11:0] min_code_o, // picture minimum luminance code
    output logic [11:0] picture_peak_luma_code_o, // picture peak luminance code
    output logic [11:0] picture_mean_luma_code_o, // picture mean luminance code
    output logic [11:0] target_display_peak_code_o, // target display peak code
    output logic [4:0][11:0] trim_o, // slope, offset, power, chroma, sat
    output logic [15:0] ul_x_o, // active area upper-left x
    output logic [15:0] ul_y_o, // active area upper-left y
    output logic [15:0] lr_x_o, // active area lower-right x
    output logic [15:0] lr_y_o // active area lower-right y
);
    dmm_pstate_t s_reg;
    dmm_pstate_t s_next;

    // payload bits that carry fields for each defined level; the rest is padding
    function automatic logic [12:0] use_bits(input logic [7:0] level);
        unique case (level)
            `DMM_LEVEL_RANGE: use_bits = `DMM_L1_USE;
            `DMM_LEVEL_TRIM: use_bits = `DMM_L2_USE;
            `DMM_LEVEL_AREA: use_bits = `DMM_L5_USE;
            default: use_bits = 13'h0000;
        endcase
    endfunction

    // only levels 1, 2 and 5 carry content; other levels are consumed silently
    function automatic logic known(input logic [7:0] level);
        known = (level == `DMM_LEVEL_RANGE) || (level == `DMM_LEVEL_TRIM) || (level == `DMM_LEVEL_AREA);
    endfunction

    always_comb
    begin
        logic [6:0] idx;
        logic [12:0] ubits;
        logic [12:0] lenok;
        logic [12:0] fend;
        logic [11:0] tgt;
        logic [12:0] wt;
        logic dup;
        idx = 7'h00;
        ubits = use_bits(s_reg.level);
        lenok = 13'h0000;
        fend = 13'h0000;
        tgt = s_reg.pay[84:73];
        wt = s_reg.pay[12:0];
        dup = 1'b0;
        s_next = s_reg;
        s_next.blk_valid = 1'b0;
        link.hdr_ready = (s_reg.st == DMM_P_IDLE);
        link.bit_ready = (s_reg.st == DMM_P_BITS);
        unique case (s_reg.st)
            DMM_P_IDLE:
            begin
                if (link.hdr_valid)
                begin
                    // a new message starts with an empty duplicate memory
                    if (link.hdr_first)
                    begin
                        s_next.nseen = 5'h00; // RQ4
                    end
                    s_next.level = link.hdr_level;
                    s_next.len = link.hdr_len;
                    s_next.lenbits = {link.hdr_len, 3'h0}; // RQ12
                    s_next.bitcnt = 13'h0000;
                    s_next.pay = '0;
                    s_next.pad_err = 1'b0;
                    s_next.st = (link.hdr_len == 10'h000) ? DMM_P_DONE : DMM_P_BITS;
                end
            end
            DMM_P_BITS:
            begin
                if (link.bit_valid)
                begin
                    // used bits land msb first; later bits are padding
                    if (s_reg.bitcnt < ubits)
                    begin
                        idx = 7'(13'(`DMM_PAY_W - 1) - s_reg.bitcnt);
                        s_next.pay[idx] = link.bit_data;
                    end
                    else if (link.bit_data && known(s_reg.level))
                    begin
                        s_next.pad_err = 1'b1; // RQ11 RQ13
                    end
                    s_next.bitcnt = s_reg.bitcnt + 13'h0001;
                    if (s_reg.bitcnt + 13'h0001 == s_reg.lenbits)
                    begin
                        s_next.st = DMM_P_DONE;
                    end
                end
            end
            // decode cycle: only the fields of this block's level change
            DMM_P_DONE:
            begin
                s_next.st = DMM_P_IDLE;
                s_next.blk_valid = known(s_reg.level); // RQ13 RQ14
                s_next.blk_level = s_reg.level;
                s_next.err = 5'h00;
                s_next.err[`DMM_ERR_PAD] = s_reg.pad_err; // RQ11
                if (s_reg.level == `DMM_LEVEL_RANGE)
                begin
                    s_next.min_code = s_reg.pay[84:73];
                    s_next.peak_code = s_reg.pay[72:61];
                    s_next.mean_code = s_reg.pay[60:49]; // RQ2
                    s_next.err[`DMM_ERR_RANGE] = (s_reg.pay[72:61] > `DMM_CODE_MAX); // RQ1
                    lenok = `DMM_L1_USE;
                    s_next.err[`DMM_ERR_LEN] = (s_reg.len != `DMM_L1_LEN);
                end
                else if (s_reg.level == `DMM_LEVEL_TRIM)
                begin
                    s_next.target_code = tgt;
                    s_next.err[`DMM_ERR_RANGE] = (tgt > `DMM_CODE_MAX); // RQ3
                    // a trim whose bits fall past the payload end takes the default
                    for (int k = 0; k < 5; k++)
                    begin
                        fend = 13'(24 + 12 * k);
                        s_next.trim[k] = (s_reg.lenbits >= fend) ? s_reg.pay[72 - 12 * k -: 12]
                                                                 : `DMM_TRIM_DEFAULT; // RQ5
                    end
                    // memory keeps the first 16 distinct targets of a message; later ones are compared against them but not stored
                    for (int k = 0; k < `DMM_SEEN_N; k++)
                    begin
                        if ((5'(k) < s_reg.nseen) && (s_reg.seen[k] == tgt))
                        begin
                            dup = 1'b1;
                        end
                    end
                    s_next.err[`DMM_ERR_DUP] = dup; // RQ4
                    if (!dup && (s_reg.nseen < 5'(`DMM_SEEN_N)))
                    begin
                        s_next.seen[s_reg.nseen[3:0]] = tgt;
                        s_next.nseen = s_reg.nseen + 5'h01;
                    end
                    lenok = `DMM_L2_USE;
                    s_next.err[`DMM_ERR_WEIGHT] = (s_reg.lenbits >= `DMM_L2_USE) && (wt != `DMM_WEIGHT_RSVD); // RQ8
                    s_next.err[`DMM_ERR_LEN] = (s_reg.len != `DMM_L2_LEN);
                end
                else if (s_reg.level == `DMM_LEVEL_AREA)
                begin
                    // each 13-bit edge offset is range checked on its own
                    for (int k = 0; k < 4; k++)
                    begin
                        if (s_reg.pay[84 - 13 * k -: 13] > `DMM_EDGE_MAX)
                        begin
                            s_next.err[`DMM_ERR_RANGE] = 1'b1; // RQ9
                        end
                    end
                    // lower-right corners wrap around when an offset reaches the picture size
                    s_next.ul_x = {3'h0, s_reg.pay[84:72]}; // RQ10
                    s_next.ul_y = {3'h0, s_reg.pay[58:46]};
                    s_next.lr_x = pic_width_i - 16'h0001 - {3'h0, s_reg.pay[71:59]};
                    s_next.lr_y = pic_height_i - 16'h0001 - {3'h0, s_reg.pay[45:33]};
                    lenok = `DMM_L5_USE;
                    s_next.err[`DMM_ERR_LEN] = (s_reg.len != `DMM_L5_LEN);
                end
                // a short level 2 block is tolerated as long as its target is complete
                if (s_reg.lenbits < lenok)
                begin
                    s_next.err[`DMM_ERR_LEN] = (s_reg.level != `DMM_LEVEL_TRIM) || (s_reg.lenbits < 13'h000C);
                end
            end
            default:
            begin
                s_next.st = DMM_P_IDLE;
            end
        endcase
    end

    // trims reset to their default so an absent field reads as 2048
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            s_reg <= '{st: DMM_P_IDLE, trim: {5{`DMM_TRIM_DEFAULT}}, default: '0};
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    // decoded field outputs hold until a later block of the same level replaces them; valid pulses for levels 1, 2 and 5 only, level and flags follow every block
    assign blk_valid_o = s_reg.blk_valid; // RQ14
    assign blk_level_o = s_reg.blk_level;
    assign blk_err_o = |s_reg.err;
    assign blk_err_flags_o = s_reg.err;
    assign min_code_o = s_reg.min_code;
    assign picture_peak_luma_code_o = s_reg.peak_code;
    assign picture_mean_luma_code_o = s_reg.mean_code;
    assign target_display_peak_code_o = s_reg.target_code;
    assign trim_o = s_reg.trim;
    assign ul_x_o = s_reg.ul_x;
    assign ul_y_o = s_reg.ul_y;
    assign lr_x_o = s_reg.lr_x;
    assign lr_y_o = s_reg.lr_y;
endmodule

/* File: verif/dmm_link_assertions.sv */
// checker for the link between the metadata source end and the parser end
// assumes one clock; instantiated by the testbench beside the link interface
`timescale 1ns/1ps
module dmm_link_assertions (
    input wire logic clk_i, // clock
    input wire logic resetn_i, // async reset, active low
    input wire logic hdr_valid, // header offered
    input wire logic hdr_first, // first block of message
    input wire logic [7:0] hdr_level, // block level
    input wire logic [9:0] hdr_len, // payload bytes
    input wire logic hdr_ready, // parser takes header
    input wire logic bit_valid, // payload bit offered
    input wire logic bit_data, // payload bit
    input wire logic bit_ready // parser takes bit
);
    logic [12:0] cnt_reg;
    logic [12:0] lenb_reg;
    logic [7:0] lvl_reg;
    logic [12:0] use_bits;
    logic bit_take;
    assign bit_take = bit_valid && bit_ready;
    // bit position within the current payload and its length
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            cnt_reg <= 13'h0000;
            lenb_reg <= 13'h0000;
            lvl_reg <= 8'h00;
        end
        else if (hdr_valid && hdr_ready)
        begin
            cnt_reg <= 13'h0000;
            lenb_reg <= {hdr_len, 3'b000};
            lvl_reg <= hdr_level;
        end
        else if (bit_take)
            cnt_reg <= cnt_reg + 13'h0001;
    end
    always_comb
    begin
        case (lvl_reg)
            8'h01: use_bits = 13'h0024;
            8'h02: use_bits = 13'h0055;
            8'h05: use_bits = 13'h0034;
            default: use_bits = 13'h1FFF;
        endcase
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    a_hdr_held_waiting: assert property (hdr_valid && !hdr_ready |=> hdr_valid && $stable(hdr_level)
        && $stable(hdr_len) && $stable(hdr_first)) else $error("header changed before taken");
    a_bit_held_waiting: assert property (bit_valid && !bit_ready |=> bit_valid && $stable(bit_data))
        else $error("payload bit changed before taken");
    a_bit_count_bound: assert property (bit_take |-> cnt_reg < lenb_reg)
        else $error("more payload bits than eight times length");
    a_hdr_after_block: assert property (hdr_valid && hdr_ready |-> cnt_reg == lenb_reg)
        else $error("header before payload complete");
    a_pad_bits_zero: assert property (bit_take && cnt_reg >= use_bits |-> !bit_data)
        else $error("padding bit set");
    a_weight_all_ones: assert property (bit_take && lvl_reg == 8'h02 && cnt_reg >= 13'h0048
        && cnt_reg < 13'h0055 |-> bit_data) else $error("reserved weight bit not one");
    a_ready_one_state: assert property (!(hdr_ready && bit_ready))
        else $error("header and bit ready together");
    a_bits_follow_hdr: assert property (hdr_valid && hdr_ready && hdr_len != 10'h000 |=> bit_valid && bit_ready)
        else $error("payload does not follow header");
    a_hdr_ready_return: assert property (bit_take && cnt_reg == lenb_reg - 13'h0001 |-> ##[1:3] hdr_ready)
        else $error("parser not idle after block");
    c_level_two: cover property (hdr_valid && hdr_ready && hdr_level == 8'h02);
    c_level_five: cover property (hdr_valid && hdr_ready && hdr_level == 8'h05);
    c_level_rsvd: cover property (hdr_valid && hdr_ready && hdr_level == 8'h03);
    c_new_message: cover property (hdr_valid && hdr_ready && hdr_first);
endmodule

/* File: verif/display_mapping_metadata_parser_test.sv */
// testbench: source end and parser end joined by the link, user sides driven and checked
// assumes the rtl files and dmm_pkg are compiled first
`timescale 1ns/1ps
module display_mapping_metadata_parser_test;
    import dmm_pkg::*;
    logic clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic req_valid_i = 1'b0;
    logic req_ready_o;
    logic req_first_i = 1'b0;
    logic [7:0] req_level_i = 8'h00;
    logic [9:0] req_len_i = 10'h000;
    logic [2:0][15:0] lum_i = {16'h2000, 16'h4E20, 16'h0000};
    logic [11:0] target_code_i = 12'h3E8;
    logic [4:0][15:0] trim_i = {16'h0006, 16'h4000, 16'h0000, 16'h1000, 16'h3000};
    logic [3:0][12:0] edge_i = {13'h1FFF, 13'h0000, 13'h0014, 13'h000A};
    logic [15:0] pic_width_i = 16'h0780;
    logic [15:0] pic_height_i = 16'h2100;
    logic blk_valid_o;
    logic [7:0] blk_level_o;
    logic blk_err_o;
    logic [4:0] blk_err_flags_o;
    logic [11:0] min_code_o;
    logic [11:0] peak_o;
    logic [11:0] mean_o;
    logic [11:0] target_o;
    logic [4:0][11:0] trim_o;
    logic [15:0] ul_x_o;
    logic [15:0] ul_y_o;
    logic [15:0] lr_x_o;
    logic [15:0] lr_y_o;
    int miscompares = 0;
    int checks = 0;
    int nblk = 0;
    always #5 clk_i = ~clk_i;
    always @(posedge clk_i) if (blk_valid_o === 1'b1) nblk <= nblk + 1;
    dmm_link_if link();
    dmm_source u_dmm_source (.clk_i(clk_i), .resetn_i(resetn_i), .link(link), .req_valid_i(req_valid_i),
        .req_ready_o(req_ready_o), .req_first_i(req_first_i), .req_level_i(req_level_i), .req_len_i(req_len_i),
        .lum_i(lum_i), .target_code_i(target_code_i), .trim_i(trim_i), .edge_i(edge_i));
    dmm_parser u_dmm_parser (.clk_i(clk_i), .resetn_i(resetn_i), .link(link), .pic_width_i(pic_width_i),
        .pic_height_i(pic_height_i), .blk_valid_o(blk_valid_o), .blk_level_o(blk_level_o), .blk_err_o(blk_err_o),
        .blk_err_flags_o(blk_err_flags_o), .min_code_o(min_code_o), .picture_peak_luma_code_o(peak_o),
        .picture_mean_luma_code_o(mean_o), .target_display_peak_code_o(target_o), .trim_o(trim_o),
        .ul_x_o(ul_x_o), .ul_y_o(ul_y_o), .lr_x_o(lr_x_o), .lr_y_o(lr_y_o));
    dmm_link_assertions u_dmm_link_assertions (.clk_i(clk_i), .resetn_i(resetn_i), .hdr_valid(link.hdr_valid),
        .hdr_first(link.hdr_first), .hdr_level(link.hdr_level), .hdr_len(link.hdr_len),
        .hdr_ready(link.hdr_ready), .bit_valid(link.bit_valid), .bit_data(link.bit_data),
        .bit_ready(link.bit_ready));
    task automatic complete_run();
        if (miscompares == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk_val(input string name, input logic [15:0] exp, input logic [15:0] got);
        checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask
    // luminance code: round half up of v*4095 in Q2.14, clipped
    function automatic logic [15:0] q_lum(input int v);
        int c;
        c = (v * 4095 + 8192) / 16384;
        return (c > 4095) ? 16'h0FFF : 16'(c);
    endfunction
    // trim code: round((v - or + 0.5) * 4096), clipped
    function automatic logic [15:0] q_trim(input int v, input bit plus);
        int c;
        c = (v + 2) / 4 + (plus ? 2048 : -2048);
        return (c < 0) ? 16'h0000 : (c > 4095) ? 16'h0FFF : 16'(c);
    endfunction
    task automatic send_blk(input logic f, input logic [7:0] lv, input logic [9:0] ln, input int nexp);
        int i;
        int n0;
        for (i = 0; i < 1000 && req_ready_o !== 1'b1; i++) @(posedge clk_i) #1;
        n0 = nblk;
        req_first_i = f;
        req_level_i = lv;
        req_len_i = ln;
        req_valid_i = 1'b1;
        @(posedge clk_i) #1;
        req_valid_i = 1'b0;
        for (i = 0; i < 1000 && req_ready_o !== 1'b1; i++) @(posedge clk_i) #1;
        repeat (4) @(posedge clk_i);
        #1;
        chk_val("block count", 16'(nexp), 16'(nblk - n0));
    endtask
    task automatic t_range();
        send_blk(1'b1, 8'h01, 10'h005, 1);
        chk_val("min", 16'(q_lum(0)), 16'(min_code_o));
        chk_val("peak", q_lum(20000), 16'(peak_o));
        chk_val("mean", q_lum(8192), 16'(mean_o));
        chk_val("flags l1", 16'h0000, 16'({blk_err_o, blk_err_flags_o}));
    endtask
    task automatic t_trim();
        int k;
        send_blk(1'b1, 8'h02, 10'h00B, 1);
        chk_val("target", 16'h03E8, 16'(target_o));
        for (k = 0; k < 5; k++)
            chk_val("trim", q_trim(int'(trim_i[k]), k == 1 || k > 2), 16'(trim_o[k]));
        chk_val("flags l2", 16'h0000, 16'({blk_err_o, blk_err_flags_o}));
    endtask
    task automatic t_dup();
        send_blk(1'b0, 8'h02, 10'h00B, 1);
        chk_val("dup flag", 16'h0001, 16'(blk_err_o & blk_err_flags_o[1]));
    endtask
    task automatic t_short();
        int k;
        send_blk(1'b1, 8'h02, 10'h004, 1);
        chk_val("short dup", 16'h0000, 16'(blk_err_flags_o[1]));
        chk_val("short slope", q_trim(int'(trim_i[0]), 1'b0), 16'(trim_o[0]));
        for (k = 1; k < 5; k++)
            chk_val("trim default", 16'h0800, 16'(trim_o[k]));
    endtask
    task automatic t_area();
        send_blk(1'b1, 8'h05, 10'h007, 1);
        chk_val("ul x", 16'h000A, ul_x_o);
        chk_val("ul y", 16'h0000, ul_y_o);
        chk_val("lr x", pic_width_i - 16'h0001 - 16'h0014, lr_x_o);
        chk_val("lr y", pic_height_i - 16'h0001 - 16'h1FFF, lr_y_o);
        chk_val("flags l5", 16'h0000, 16'({blk_err_o, blk_err_flags_o}));
    endtask
    task automatic t_reserved();
        logic [7:0] lv[5] = '{8'h00, 8'h03, 8'h04, 8'h06, 8'hFF};
        int k;
        for (k = 0; k < 5; k++)
            send_blk(1'b0, lv[k], 10'h002, 0);
        chk_val("peak held", q_lum(20000), 16'(peak_o));
    endtask
    task automatic t_len();
        send_blk(1'b1, 8'h01, 10'h006, 1);
        chk_val("len flag", 16'h0001, 16'(blk_err_o & blk_err_flags_o[4]));
        chk_val("len level", 16'h0001, 16'(blk_level_o));
        send_blk(1'b1, 8'h01, 10'h000, 1);
        chk_val("empty len flag", 16'h0001, 16'(blk_err_o & blk_err_flags_o[4]));
    endtask
    initial
    begin
        #50000;
        miscompares++;
        complete_run();
    end
    initial
    begin
        repeat (20) @(posedge clk_i);
        #1;
        resetn_i = 1'b1;
        t_range();
        t_trim();
        t_dup();
        t_short();
        t_area();
        t_reserved();
        t_len();
        complete_run();
    end
endmodule
